// ===== rtl/ring_osc_counter.v
/*
 * One ring oscillator counter: counts on the oscillator's own edge while
 * enabled and hands its value to the tile clock through two flip-flops.
 * Assumes the count is read only once the oscillator has been stopped.
 */
`timescale 1ns/10ps
`include "tile_regs_defines.vh"

module ring_osc_counter (
   input wire osc_clk,
   input wire clock,
   input wire run,
   output wire [15:0] count
);

   // The count starts at zero once and is never touched by reset.
   reg [15:0] osc_count_r = `OSC_COUNT_INIT;
   reg run_meta_r = 1'b0;
   reg run_sync_r = 1'b0;
   reg [15:0] cnt_meta_r = `OSC_COUNT_INIT;
   reg [15:0] cnt_sync_r = `OSC_COUNT_INIT;

   always @(posedge osc_clk) begin
      run_meta_r <= run;
      run_sync_r <= run_meta_r;
      if (run_sync_r) begin
         osc_count_r <= osc_count_r + 16'h0001;
      end
   end

   always @(posedge clock) begin
      cnt_meta_r <= osc_count_r;
      cnt_sync_r <= cnt_meta_r;
   end

   assign count = cnt_sync_r;

endmodule

// ===== rtl/tile_config_status_regs.v
/*
 * Per-tile configuration and status register bank reached by token-framed
 * read and write messages, with tile control outputs, boot status, security
 * copy and four ring oscillator counters.
 * Assumes a byte stream with a control flag on each side and a tile clock.
 */
`timescale 1ns/10ps
`include "tile_regs_defines.vh"

module tile_config_status_regs (
   input wire clock,
   input wire srst,
   input wire rx_valid,
   input wire rx_ctrl,
   input wire [7:0] rx_data,
   output wire rx_ready,
   output wire tx_valid,
   output wire tx_ctrl,
   output wire [7:0] tx_data,
   input wire tx_ready,
   output wire [23:0] resp_chanend,
   input wire pll_tick,
   input wire all_threads_paused,
   input wire [7:0] proc_number,
   input wire boot_mode_override,
   input wire core1_powered_off,
   input wire skip_otp_level_poll,
   input wire boot_from_ram,
   input wire boot_from_jtag,
   input wire [1:0] boot_clk_mode_pins,
   input wire otp_load,
   input wire [31:0] otp_security_word,
   input wire [3:0] osc_clk,
   output wire [7:0] rgmii_tx_delay,
   output reg rgmii_tx_clk,
   output wire rgmii_periph_en,
   output reg lowpower_div_active,
   output wire usb_utmi_sel,
   output wire ulpi_support_en,
   output wire [3:0] otp_sector_lock,
   output wire otp_redundancy_en,
   output wire boot_from_otp,
   output wire jtag_cfg_access_block,
   output wire jtag_debug_block,
   output wire global_debug_block
);

   localparam ST_IDLE = 2'd0;
   localparam ST_HDR = 2'd1;
   localparam ST_BODY = 2'd2;
   localparam ST_RESP = 2'd3;

   reg [1:0] state_r;
   reg is_write_r;
   reg bad_r;
   reg [2:0] hdr_cnt_r;
   reg [23:0] chan_r;
   reg [7:0] regnum_r;
   reg [7:0] size_r;
   reg [31:0] wdata_r;
   reg [2:0] dcnt_r;
   reg [53:0] resp_sh_r;
   reg [2:0] resp_left_r;

   reg [31:0] ctrl_r;
   reg [31:0] sec_r;
   reg [1:0] osc_ctrl_r;
   reg [8:0] txc_cnt_r;
   reg [1:0] pins_meta_r;
   reg [1:0] pins_sync_r;

   reg [31:0] rd_word;
   reg [31:0] boot_word;
   reg reg_readable;
   reg reg_writable;

   wire [15:0] osc_count [0:3];
   wire rx_fire;
   wire end_msg;
   wire ok_read;
   wire ok_write;
   wire [8:0] tx_div;

   ////////////////////////////////////////////////////////////////////////
   // Message framing.

   assign rx_ready = (state_r != ST_RESP);
   assign rx_fire = rx_valid & rx_ready;
   assign end_msg = rx_fire & rx_ctrl & (rx_data == `TOK_END) &
                    ((state_r == ST_HDR) | (state_r == ST_BODY));

   assign ok_read = ~bad_r & ~is_write_r & (state_r == ST_BODY) &
                    (size_r == `MSG_SIZE) & reg_readable;
   assign ok_write = ~bad_r & is_write_r & (state_r == ST_BODY) &
                     (size_r == `MSG_SIZE) &
                     (dcnt_r == `MSG_WORD_BYTES) & reg_writable;

   assign tx_valid = (state_r == ST_RESP);
   assign tx_ctrl = resp_sh_r[8];
   assign tx_data = resp_sh_r[7:0];
   assign resp_chanend = chan_r;

   always @(posedge clock) begin
      if (srst) begin
         state_r <= ST_IDLE;
         is_write_r <= 1'b0;
         bad_r <= 1'b0;
         hdr_cnt_r <= 3'd0;
         chan_r <= 24'h000000;
         regnum_r <= 8'h00;
         size_r <= 8'h00;
         wdata_r <= 32'h00000000;
         dcnt_r <= 3'd0;
         resp_sh_r <= 54'h0;
         resp_left_r <= 3'd0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (rx_fire & rx_ctrl) begin
                  if (rx_data == `TOK_WRITE || rx_data == `TOK_READ) begin
                     is_write_r <= (rx_data == `TOK_WRITE);
                     bad_r <= 1'b0;
                     hdr_cnt_r <= 3'd0;
                     dcnt_r <= 3'd0;
                     wdata_r <= 32'h00000000;
                     state_r <= ST_HDR;
                  end
               end
            end
            ST_HDR: begin
               if (rx_fire & rx_ctrl) begin
                  bad_r <= 1'b1;
               end else if (rx_fire) begin
                  if (hdr_cnt_r < 3'd3) begin
                     chan_r <= {chan_r[15:0], rx_data};
                  end else if (hdr_cnt_r == 3'd3) begin
                     regnum_r <= rx_data;
                  end else begin
                     size_r <= rx_data;
                     state_r <= ST_BODY;
                  end
                  hdr_cnt_r <= hdr_cnt_r + 3'd1;
               end
            end
            ST_BODY: begin
               if (rx_fire & rx_ctrl) begin
                  bad_r <= 1'b1;
               end else if (rx_fire) begin
                  if (is_write_r && dcnt_r < `MSG_WORD_BYTES) begin
                     wdata_r <= {wdata_r[23:0], rx_data};
                     dcnt_r <= dcnt_r + 3'd1;
                  end else begin
                     bad_r <= 1'b1;
                  end
               end
            end
            ST_RESP: begin
               if (tx_ready) begin
                  resp_sh_r <= {9'h000, resp_sh_r[53:9]};
                  resp_left_r <= resp_left_r - 3'd1;
                  if (resp_left_r == 3'd1) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
         // The closing token wins over the framing above.
         if (end_msg) begin
            state_r <= ST_RESP;
            if (ok_read) begin
               resp_sh_r <= {1'b1, `TOK_END, 1'b0, rd_word[7:0],
                             1'b0, rd_word[15:8], 1'b0, rd_word[23:16],
                             1'b0, rd_word[31:24], 1'b1, `TOK_ACK};
               resp_left_r <= 3'd6;
            end else if (ok_write) begin
               resp_sh_r <= {36'h0, 1'b1, `TOK_END, 1'b1, `TOK_ACK};
               resp_left_r <= 3'd2;
            end else begin
               resp_sh_r <= {36'h0, 1'b1, `TOK_END, 1'b1, `TOK_NACK};
               resp_left_r <= 3'd2;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode and read data.

   always @* begin
      boot_word = 32'h00000000;
      boot_word[`BOOT_PROC_MSB:`BOOT_PROC_LSB] = proc_number;
      boot_word[`BOOT_OVERRIDE] = boot_mode_override;
      boot_word[`BOOT_CORE1_OFF] = core1_powered_off;
      boot_word[`BOOT_SKIP_POLL] = skip_otp_level_poll;
      boot_word[`BOOT_FROM_RAM] = boot_from_ram;
      boot_word[`BOOT_FROM_JTAG] = boot_from_jtag;
      boot_word[`BOOT_PINS_MSB:`BOOT_PINS_LSB] = pins_sync_r;
   end

   always @* begin
      rd_word = 32'h00000000;
      reg_readable = 1'b1;
      reg_writable = 1'b0;
      case (regnum_r)
         `REG_TILE_CTRL: begin
            rd_word = ctrl_r;
            reg_writable = 1'b1;
         end
         `REG_BOOT_STATUS: begin
            rd_word = boot_word;
         end
         `REG_SECURITY: begin
            rd_word = sec_r;
            reg_writable = ~sec_r[`SEC_WLOCK];
         end
         `REG_OSC_CTRL: begin
            rd_word = {30'h0, osc_ctrl_r};
            reg_writable = 1'b1;
         end
         `REG_OSC_CELL: begin
            rd_word = {16'h0000, osc_count[0]};
         end
         `REG_OSC_WIRE: begin
            rd_word = {16'h0000, osc_count[1]};
         end
         `REG_OSC_PCELL: begin
            rd_word = {16'h0000, osc_count[2]};
         end
         `REG_OSC_PWIRE: begin
            rd_word = {16'h0000, osc_count[3]};
         end
         default: begin
            reg_readable = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register storage.

   always @(posedge clock) begin
      if (srst) begin
         ctrl_r <= `CTRL_RESET;
         osc_ctrl_r <= `OSC_CTRL_RESET;
      end else if (end_msg & ok_write) begin
         if (regnum_r == `REG_TILE_CTRL) begin
            ctrl_r <= wdata_r & `CTRL_WMASK;
         end
         if (regnum_r == `REG_OSC_CTRL) begin
            osc_ctrl_r <= wdata_r[1:0];
         end
      end
   end

   // A load from one-time memory overrides a write in the same cycle.
   always @(posedge clock) begin
      if (srst) begin
         sec_r <= `SEC_RESET;
      end else if (otp_load) begin
         sec_r <= otp_security_word & `SEC_WMASK;
      end else if (end_msg & ok_write & (regnum_r == `REG_SECURITY)) begin
         sec_r <= wdata_r & `SEC_WMASK;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         pins_meta_r <= 2'b00;
         pins_sync_r <= 2'b00;
      end else begin
         pins_meta_r <= boot_clk_mode_pins;
         pins_sync_r <= pins_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tile control outputs.

   assign rgmii_tx_delay = ctrl_r[`CTRL_DELAY_MSB:`CTRL_DELAY_LSB];
   assign tx_div = ctrl_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
   assign rgmii_periph_en = ctrl_r[`CTRL_PERIPH_EN];
   assign usb_utmi_sel = ctrl_r[`CTRL_UTMI_SEL];
   assign ulpi_support_en = ctrl_r[`CTRL_ULPI_EN];

   // The divider counter advances once per phase-locked loop tick.
   always @(posedge clock) begin
      if (srst) begin
         txc_cnt_r <= 9'h000;
         rgmii_tx_clk <= 1'b0;
      end else if (pll_tick) begin
         if (txc_cnt_r == tx_div) begin
            txc_cnt_r <= 9'h000;
            rgmii_tx_clk <= 1'b1;
         end else begin
            txc_cnt_r <= txc_cnt_r + 9'h001;
            if (txc_cnt_r == {1'b0, tx_div[8:1]}) begin
               rgmii_tx_clk <= 1'b0;
            end
         end
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         lowpower_div_active <= 1'b0;
      end else begin
         lowpower_div_active <= ctrl_r[`CTRL_DIV_EN] &
                                (~ctrl_r[`CTRL_DYNAMIC] |
                                 all_threads_paused);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Security outputs.

   assign otp_sector_lock = sec_r[`SEC_LOCK_MSB:`SEC_LOCK_LSB] |
                            {4{sec_r[`SEC_LOCK_ALL]}};
   assign otp_redundancy_en = sec_r[`SEC_REDUND];
   assign boot_from_otp = sec_r[`SEC_OTP_BOOT];
   assign jtag_cfg_access_block = sec_r[`SEC_JTAG_CFG];
   assign jtag_debug_block = sec_r[`SEC_JTAG_TAP];
   assign global_debug_block = sec_r[`SEC_GLOBAL_DBG];

   ////////////////////////////////////////////////////////////////////////
   // Ring oscillator counters; the first two are core, the rest peripheral.

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : osc
         ring_osc_counter u_cnt (
            .osc_clk(osc_clk[gi]),
            .clock(clock),
            .run((gi < 2) ? osc_ctrl_r[`OSC_CORE_EN] :
                            osc_ctrl_r[`OSC_PERIPH_EN]),
            .count(osc_count[gi])
         );
      end
   endgenerate

endmodule

// ===== rtl/tile_regs_defines.vh
/*
 * Constants of the tile configuration and status register bank: message
 * tokens, register numbers, field positions, write masks and reset values.
 * Assumes it is included by its bare name and holds definitions only.
 */
`ifndef TILE_REGS_DEFINES_VH
`define TILE_REGS_DEFINES_VH

`define TOK_WRITE 8'h24
`define TOK_READ 8'h25
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04
`define MSG_SIZE 8'h04
`define MSG_WORD_BYTES 3'd4
`define HDR_LAST 3'd4

`define REG_TILE_CTRL 8'h02
`define REG_BOOT_STATUS 8'h03
`define REG_SECURITY 8'h05
`define REG_OSC_CTRL 8'h06
`define REG_OSC_CELL 8'h07
`define REG_OSC_WIRE 8'h08
`define REG_OSC_PCELL 8'h09
`define REG_OSC_PWIRE 8'h0A

`define CTRL_DELAY_MSB 25
`define CTRL_DELAY_LSB 18
`define CTRL_DIV_MSB 17
`define CTRL_DIV_LSB 9
`define CTRL_PERIPH_EN 8
`define CTRL_DYNAMIC 5
`define CTRL_DIV_EN 4
`define CTRL_UTMI_SEL 2
`define CTRL_ULPI_EN 1
`define CTRL_WMASK 32'h03FFFF36
`define CTRL_RESET 32'h00000000

`define BOOT_PROC_MSB 23
`define BOOT_PROC_LSB 16
`define BOOT_OVERRIDE 8
`define BOOT_CORE1_OFF 5
`define BOOT_SKIP_POLL 4
`define BOOT_FROM_RAM 3
`define BOOT_FROM_JTAG 2
`define BOOT_PINS_MSB 1
`define BOOT_PINS_LSB 0

`define SEC_WLOCK 31
`define SEC_GLOBAL_DBG 14
`define SEC_LOCK_ALL 12
`define SEC_LOCK_MSB 11
`define SEC_LOCK_LSB 8
`define SEC_REDUND 7
`define SEC_OTP_BOOT 5
`define SEC_JTAG_CFG 4
`define SEC_JTAG_TAP 0
`define SEC_WMASK 32'h80005FB1
`define SEC_RESET 32'h00000000

`define OSC_CORE_EN 1
`define OSC_PERIPH_EN 0
`define OSC_CTRL_RESET 2'h0
`define OSC_COUNT_INIT 16'h0000

`endif

// ===== test/msg_requester.sv
/* Requester model: sends token-framed register messages, sinks answers.
   Assumes one tile clock and a bank that takes an item while ready. */
`timescale 1ns/10ps
`include "tile_regs_defines.vh"
module msg_requester (
   input wire clock,
   input wire stall_en,
   input wire rx_ready,
   output reg rx_valid,
   output reg rx_ctrl,
   output reg [7:0] rx_data,
   output reg tx_ready
);
   initial begin
      rx_valid = 1'b0;
      rx_ctrl = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
   end
   // Answer sink stalls every other cycle when asked to.
   always @(posedge clock) begin
      tx_ready <= !stall_en || !tx_ready;
   end
   task put(input c, input [7:0] d);
      begin
         rx_valid <= 1'b1;
         rx_ctrl <= c;
         rx_data <= d;
         @(negedge clock);
         while (!rx_ready) @(negedge clock);
         @(posedge clock);
      end
   endtask
   task msg(input [7:0] op, input [23:0] ch, input [7:0] r,
         input [7:0] sz, input [31:0] d, input [2:0] nb);
      integer i;
      begin
         put(1'b1, op);
         for (i = 2; i >= 0; i--) put(1'b0, ch[8*i+:8]);
         put(1'b0, r);
         put(1'b0, sz);
         for (i = 0; i < nb; i++) put(1'b0, d[8*(3-i)+:8]);
         put(1'b1, `TOK_END);
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
      end
   endtask
endmodule

// ===== test/tb.sv
/* Self-checking bench of the tile register bank.
   Assumes the requester model and the bound checker are compiled. */
`timescale 1ns/10ps
`include "tile_regs_defines.vh"
module tb;
   reg clock, srst, pll_tick, all_threads_paused, boot_mode_override;
   reg core1_powered_off, skip_otp_level_poll, boot_from_ram;
   reg boot_from_jtag, otp_load, stall_en, prev;
   reg [7:0] proc_number;
   reg [1:0] boot_clk_mode_pins;
   reg [31:0] otp_security_word, rnd, v, w, cap, c7;
   reg [3:0] osc_clk;
   reg [9:0] head;
   reg [9:0] exp_q [$];
   integer n_mismatch = 0, samples_checked = 0, cyc = 0, k, n;
   wire rx_valid, rx_ctrl, rx_ready, tx_valid, tx_ctrl, tx_ready;
   wire rgmii_tx_clk, rgmii_periph_en, lowpower_div_active;
   wire usb_utmi_sel, ulpi_support_en, otp_redundancy_en, boot_from_otp;
   wire jtag_cfg_access_block, jtag_debug_block, global_debug_block;
   wire [7:0] rx_data, tx_data, rgmii_tx_delay;
   wire [23:0] resp_chanend;
   wire [3:0] otp_sector_lock;
   tile_config_status_regs tile_config_status_regs_inst (.clock, .srst,
      .rx_valid, .rx_ctrl, .rx_data, .rx_ready, .tx_valid, .tx_ctrl,
      .tx_data, .tx_ready, .resp_chanend, .pll_tick, .all_threads_paused,
      .proc_number, .boot_mode_override, .core1_powered_off,
      .skip_otp_level_poll, .boot_from_ram, .boot_from_jtag,
      .boot_clk_mode_pins, .otp_load, .otp_security_word, .osc_clk,
      .rgmii_tx_delay, .rgmii_tx_clk, .rgmii_periph_en,
      .lowpower_div_active, .usb_utmi_sel, .ulpi_support_en,
      .otp_sector_lock, .otp_redundancy_en, .boot_from_otp,
      .jtag_cfg_access_block, .jtag_debug_block, .global_debug_block);
   msg_requester msg_requester_inst (.clock, .stall_en, .rx_ready,
      .rx_valid, .rx_ctrl, .rx_data, .tx_ready);
   always #5 clock = ~clock;
   // Free-running oscillators, unrelated to the tile clock.
   always #1.7 osc_clk[0] = ~osc_clk[0];
   always #2.3 osc_clk[1] = ~osc_clk[1];
   always #2.9 osc_clk[2] = ~osc_clk[2];
   always #3.1 osc_clk[3] = ~osc_clk[3];
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task nxt;
      rnd = lfsr(rnd);
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked++;
         if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   task xfer(input [7:0] op, input [7:0] r, input [7:0] sz,
         input [31:0] d, input [2:0] nb, input ok, input [31:0] e,
         input cp);
      integer i;
      begin
         nxt;
         v = rnd;
         exp_q.push_back({2'b01, (ok ? `TOK_ACK : `TOK_NACK)});
         if (ok && op == `TOK_READ)
            for (i = 3; i >= 0; i--) exp_q.push_back({cp, 1'b0, e[8*i+:8]});
         exp_q.push_back({2'b01, `TOK_END});
         msg_requester_inst.msg(op, v[23:0], r, sz, d, nb);
         i = 0;
         while (exp_q.size() != 0 && i < 300) begin
            @(negedge clock);
            i++;
         end
         @(posedge clock);
         chk("answer drain", 0, exp_q.size());
         chk("return channel end", v[23:0], resp_chanend);
      end
   endtask
   task rd(input [7:0] r, input [31:0] e);
      xfer(`TOK_READ, r, `MSG_SIZE, 0, 0, 1'b1, e, 1'b0);
   endtask
   task wr(input [7:0] r, input [31:0] d, input ok);
      xfer(`TOK_WRITE, r, `MSG_SIZE, d, 4, ok, 0, 1'b0);
   endtask
   always @(posedge clock) begin
      if (tx_valid && tx_ready) begin
         head = exp_q.size() ? exp_q.pop_front() : 10'h1FF;
         samples_checked++;
         if (head[9])
            cap <= {cap[23:0], tx_data};
         else if ({tx_ctrl, tx_data} !== head[8:0]) begin
            n_mismatch++;
            $display("unexpected answer: expected %h seen %h", head[8:0],
               {tx_ctrl, tx_data});
         end
      end
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   ////////////////////////////////////////
   initial begin
      {clock, srst, osc_clk, rnd} = {6'h11, 32'h76FC};
      {pll_tick, all_threads_paused, boot_mode_override, core1_powered_off,
         skip_otp_level_poll, boot_from_ram, boot_from_jtag, otp_load,
         stall_en, proc_number, boot_clk_mode_pins} = 19'h00000;
      otp_security_word = 32'h00000000;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(`REG_TILE_CTRL, 0);
      rd(`REG_OSC_CTRL, 0);
      rd(`REG_OSC_CELL, 0);
      stall_en <= 1'b1;
      for (k = 0; k < 4; k++) begin
         nxt;
         w = rnd;
         wr(`REG_TILE_CTRL, w, 1'b1);
         rd(`REG_TILE_CTRL, w & `CTRL_WMASK);
         chk("control outputs", {w[25:18], w[8], w[2], w[1]}, {rgmii_tx_delay,
            rgmii_periph_en, usb_utmi_sel, ulpi_support_en});
      end
      for (k = 0; k < 4; k++) begin
         all_threads_paused <= k[0];
         wr(`REG_TILE_CTRL, {26'h0, k[1], 5'h10}, 1'b1);
         repeat (2) @(posedge clock);
         chk("divider", !k[1] || k[0], lowpower_div_active);
      end
      wr(`REG_TILE_CTRL, 32'h00000600, 1'b1);
      pll_tick <= 1'b1;
      repeat (8) @(negedge clock);
      prev = rgmii_tx_clk;
      n = 0;
      repeat (40) begin
         @(negedge clock);
         n = n + (rgmii_tx_clk && !prev);
         prev = rgmii_tx_clk;
      end
      chk("tx clock rises", 10, n);
      @(posedge clock);
      pll_tick <= 1'b0;
      nxt;
      w = rnd;
      {proc_number, boot_mode_override, core1_powered_off,
         skip_otp_level_poll, boot_from_ram, boot_from_jtag,
         boot_clk_mode_pins} <= w[14:0];
      repeat (4) @(posedge clock);
      rd(`REG_BOOT_STATUS, {8'h00, w[14:7], 7'h00, w[6], 2'h0, w[5:0]});
      wr(`REG_BOOT_STATUS, w, 1'b0);
      nxt;
      w = rnd & 32'h7FFFFFFF;
      otp_security_word <= w;
      otp_load <= 1'b1;
      @(posedge clock);
      otp_load <= 1'b0;
      @(posedge clock);
      rd(`REG_SECURITY, w & `SEC_WMASK);
      chk("security outputs", {w[11:8] | {4{w[12]}}, w[7], w[5], w[4], w[0],
         w[14]}, {otp_sector_lock, otp_redundancy_en, boot_from_otp,
         jtag_cfg_access_block, jtag_debug_block, global_debug_block});
      wr(`REG_SECURITY, 32'h80001000, 1'b1);
      wr(`REG_SECURITY, 32'h00000000, 1'b0);
      rd(`REG_SECURITY, 32'h80001000);
      chk("sector locks", 4'hF, otp_sector_lock);
      xfer(`TOK_READ, 8'h04, `MSG_SIZE, 0, 0, 1'b0, 0, 1'b0);
      xfer(`TOK_READ, `REG_TILE_CTRL, 8'h02, 0, 0, 1'b0, 0, 1'b0);
      xfer(`TOK_WRITE, `REG_OSC_CTRL, `MSG_SIZE, 3, 3, 1'b0, 0, 1'b0);
      wr(`REG_OSC_CTRL, 32'h00000002, 1'b1);
      repeat (60) @(posedge clock);
      wr(`REG_OSC_CTRL, 32'h00000000, 1'b1);
      repeat (12) @(posedge clock);
      xfer(`TOK_READ, `REG_OSC_CELL, `MSG_SIZE, 0, 0, 1'b1, 0, 1'b1);
      c7 = cap;
      chk("cell count moved", 1, c7 != 0);
      xfer(`TOK_READ, `REG_OSC_WIRE, `MSG_SIZE, 0, 0, 1'b1, 0, 1'b1);
      chk("wire count moved", 1, cap != 0);
      rd(`REG_OSC_PCELL, 0);
      rd(`REG_OSC_PWIRE, 0);
      wr(`REG_OSC_CTRL, 32'h00000001, 1'b1);
      repeat (60) @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      repeat (12) @(posedge clock);
      rd(`REG_OSC_CELL, c7);
      rd(`REG_OSC_CTRL, 0);
      rd(`REG_TILE_CTRL, `CTRL_RESET);
      rd(`REG_SECURITY, `SEC_RESET);
      xfer(`TOK_READ, `REG_OSC_PCELL, `MSG_SIZE, 0, 0, 1'b1, 0, 1'b1);
      chk("peripheral count kept", 1, cap != 0);
      wrap_up;
   end
endmodule

// ===== test/tile_regs_properties.sv
/* Checker of the answer stream and control outputs of the bank.
   Assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/10ps
`include "tile_regs_defines.vh"
module tile_regs_properties (
   input wire clock,
   input wire srst,
   input wire rx_ready,
   input wire tx_valid,
   input wire tx_ctrl,
   input wire [7:0] tx_data,
   input wire tx_ready,
   input wire pll_tick,
   input wire otp_load,
   input wire [31:0] otp_security_word,
   input wire [7:0] rgmii_tx_delay,
   input wire rgmii_tx_clk,
   input wire rgmii_periph_en,
   input wire lowpower_div_active,
   input wire usb_utmi_sel,
   input wire ulpi_support_en,
   input wire [3:0] otp_sector_lock,
   input wire otp_redundancy_en,
   input wire boot_from_otp,
   input wire jtag_cfg_access_block,
   input wire jtag_debug_block,
   input wire global_debug_block
);
   reg [31:0] w_d;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   always @(posedge clock) begin
      w_d <= otp_security_word;
   end
   sequence s_nack;
      tx_valid && tx_ready && tx_ctrl && tx_data == `TOK_NACK;
   endsequence
   sequence s_end;
      tx_valid && tx_ctrl && tx_data == `TOK_END;
   endsequence
   property p_nack_end;
      s_nack |=> s_end;
   endproperty
   a_nack_end: assert property (p_nack_end)
      else $error("failure answer not closed");
   property p_first;
      $rose(tx_valid) |-> tx_ctrl &&
         (tx_data == `TOK_ACK || tx_data == `TOK_NACK);
   endproperty
   a_first: assert property (p_first)
      else $error("answer opens with a bad token");
   property p_busy;
      tx_valid |-> !rx_ready;
   endproperty
   a_busy: assert property (p_busy)
      else $error("request taken while answering");
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
         && $stable(tx_ctrl);
   endproperty
   a_hold: assert property (p_hold)
      else $error("answer item changed while stalled");
   property p_rst_ctrl;
      $fell(srst) |-> rgmii_tx_delay == 8'h00 && !rgmii_periph_en;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl)
      else $error("media controls not cleared by reset");
   property p_rst_usb;
      $fell(srst) |-> !usb_utmi_sel && !ulpi_support_en
         && !lowpower_div_active;
   endproperty
   a_rst_usb: assert property (p_rst_usb)
      else $error("usb or divider controls not cleared");
   property p_lock;
      otp_load |=> otp_sector_lock == (w_d[11:8] | {4{w_d[12]}});
   endproperty
   a_lock: assert property (p_lock)
      else $error("sector locks differ from loaded copy");
   property p_dbg;
      otp_load |=> {jtag_cfg_access_block, jtag_debug_block,
         global_debug_block, otp_redundancy_en, boot_from_otp}
         == {w_d[4], w_d[0], w_d[14], w_d[7], w_d[5]};
   endproperty
   a_dbg: assert property (p_dbg)
      else $error("debug blocks differ from loaded copy");
   property p_txclk;
      !$past(srst) && $changed(rgmii_tx_clk) |-> $past(pll_tick);
   endproperty
   a_txclk: assert property (p_txclk)
      else $error("tx clock moved without a pll tick");
endmodule
bind tile_config_status_regs tile_regs_properties tile_regs_properties_inst (
   .clock, .srst, .rx_ready, .tx_valid, .tx_ctrl, .tx_data, .tx_ready,
   .pll_tick, .otp_load, .otp_security_word, .rgmii_tx_delay,
   .rgmii_tx_clk, .rgmii_periph_en, .lowpower_div_active, .usb_utmi_sel,
   .ulpi_support_en, .otp_sector_lock, .otp_redundancy_en, .boot_from_otp,
   .jtag_cfg_access_block, .jtag_debug_block, .global_debug_block);
